// >>> hdl/hsdr_device.sv
// Function
// [RQ1] Master alone makes start: SDA falls, SCL high
// [RQ2] Master code 00001xxx follows the start
// [RQ3] Master code: no acknowledge, switch to fast lines
// [RQ4] Master repeats start before the address byte
// [RQ5] SDA stable while SCL is high
// [RQ6] Read address: seven bits plus direction one
// [RQ7] Address match: pull SDA low on ninth clock
// [RQ8] Send upper data byte, MSB first
// [RQ9] Master acknowledges upper byte
// [RQ10] On master acknowledge, send lower data byte
// [RQ11] Master acknowledges lower byte
// [RQ12] Then send the stored control byte
// [RQ13] Master not-acknowledges, then stop or restart
// [RQ14] Data from converter or temporary register, flagged
// [RQ15] Stop ends high-speed mode
// [RQ16] Read then write uses a repeated start
// [RQ17] Match only 10011, select pin, zero
// [RQ18] Never answer broadcast address for reads
// [RQ19] After final not-acknowledge release SDA, wait
`timescale 1ns/1ps
`default_nettype none
module hsdr_device (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Bus side
    hsdr_if.dev              bus,
    // Data sources
    input  wire logic [15:0] dac_word,
    input  wire logic [15:0] temp_word,
    input  wire logic        src_temp,
    input  wire logic [7:0]  ctrl_in,
    // Address select pin
    input  wire logic        address_select_pin,
    // Status
    output logic             hs_mode,
    output logic             read_done
);
    // ================================================================
    // States
    typedef enum logic [6:0] {
        D_IDLE  = 7'h01,
        D_RXB   = 7'h02,
        D_ACK_A = 7'h04,
        D_LOAD  = 7'h08,
        D_TX    = 7'h10,
        D_ACK_M = 7'h20,
        D_WAIT  = 7'h40
    } hsdr_dstate_e;

    hsdr_dstate_e state;
    hsdr_dstate_e next_state;

    // ================================================================
    // Input synchronisers: first stage feeds only the second
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic sel_s1;
    logic sel_s2;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
            sel_s1 <= address_select_pin;
            sel_s2 <= sel_s1;
        end
    end

    // ================================================================
    // Line events
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    // Data moves only with SCL low, so SDA edges under SCL high are framing
    wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2; // see [RQ1] see [RQ5]
    wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2; // see [RQ13]

    // ================================================================
    // Bit counter and received byte
    logic [3:0] bit_cnt;
    logic [7:0] rx_sh;
    wire  [7:0] rx_byte = {rx_sh[6:0], sda_s2};
    wire        last_bit = (bit_cnt == 4'h7);

    // Master code and read address decode on the completed byte
    wire is_mcode = (rx_byte[7:3] == hsdr_pkg::MCODE_PREFIX); // see [RQ2]
    // Broadcast carries a different fifth bit, so it never matches here
    wire is_read  = (rx_byte == hsdr_pkg::addr_byte(sel_s2, 1'b1)); // see [RQ17] see [RQ18]

    // ================================================================
    // Transmit side
    logic [1:0]  byte_i;
    logic [15:0] word;
    logic [7:0]  ctrl_ret;
    logic [7:0]  tx_sh;
    logic        sda_low;

    // Source field of the returned control byte names the data source
    wire [1:0] src_code = src_temp ? hsdr_pkg::LOAD_TEMP : hsdr_pkg::LOAD_DAC;
    wire [7:0] src_mask = 8'h03 << hsdr_pkg::LOAD_LSB;
    wire [7:0] src_bits = {6'h00, src_code} << hsdr_pkg::LOAD_LSB;
    wire [7:0] next_ctrl = (ctrl_in & ~src_mask) | src_bits; // see [RQ14]

    // Byte order: upper data, lower data, control
    wire [7:0] tx_pick = (byte_i == 2'h0) ? word[15:8] :
                         (byte_i == 2'h1) ? word[7:0]  : ctrl_ret; // see [RQ8] see [RQ10] see [RQ12]
    wire       more    = (32'(byte_i) < hsdr_pkg::BYTES_READ - 1);
    wire       m_ack   = ~sda_s2;

    // Open drain: the pin is only ever pulled low
    assign bus.d_sda_o  = 1'b0;
    assign bus.d_sda_oe = sda_low;

    // ================================================================
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            D_IDLE: begin
                next_state = D_IDLE;
            end
            D_RXB: begin
                if (scl_rise && last_bit) begin
                    next_state = (is_read && !is_mcode) ? D_ACK_A : D_WAIT; // see [RQ3] see [RQ6]
                end
            end
            D_ACK_A: begin
                if (scl_fall) next_state = D_LOAD; // see [RQ7]
            end
            D_LOAD: begin
                if (scl_fall) next_state = D_TX;
            end
            D_TX: begin
                if (scl_fall && bit_cnt == 4'h8) next_state = D_ACK_M;
            end
            D_ACK_M: begin
                if (scl_rise) next_state = (m_ack && more) ? D_LOAD : D_WAIT; // see [RQ19]
            end
            D_WAIT: begin
                next_state = D_WAIT;
            end
        endcase
        // Framing overrides everything; a repeated start reopens addressing
        if (bus_start) next_state = D_RXB; // see [RQ4] see [RQ16]
        if (bus_stop) next_state = D_IDLE;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) state <= D_IDLE;
        else state <= next_state;
    end

    // ================================================================
    // Bit counter and receive shifter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
            rx_sh   <= 8'h00;
        end else if (bus_start || (state == D_LOAD && scl_fall)) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state == D_RXB || state == D_TX)) begin
            bit_cnt <= bit_cnt + 4'h1;
            rx_sh   <= rx_byte;
        end
    end

    // ================================================================
    // Snapshot of data and control at the address match
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word     <= 16'h0000;
            ctrl_ret <= 8'h00;
        end else if (state == D_RXB && scl_rise && last_bit && is_read) begin
            word     <= src_temp ? temp_word : dac_word; // see [RQ14]
            ctrl_ret <= next_ctrl;
        end
    end

    // ================================================================
    // Byte index: advances on each master acknowledge while a further byte remains
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) byte_i <= 2'h0;
        else if (state == D_ACK_A) byte_i <= 2'h0;
        else if (state == D_ACK_M && scl_rise && m_ack && more) byte_i <= byte_i + 2'h1; // see [RQ10]
    end

    // ================================================================
    // SDA drive, changed just after SCL falls, released at start or stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_low <= 1'b0;
            tx_sh   <= 8'h00;
        end else if (bus_start || bus_stop) begin
            sda_low <= 1'b0;
        end else if (scl_fall) begin
            unique case (state)
                D_ACK_A: begin
                    sda_low <= 1'b1; // see [RQ7]
                end
                D_LOAD: begin
                    tx_sh   <= tx_pick; // see [RQ8] see [RQ12]
                    sda_low <= ~tx_pick[7];
                end
                D_TX: begin
                    // After the eighth bit the master owns the ninth clock
                    tx_sh   <= {tx_sh[6:0], 1'b0};
                    sda_low <= (bit_cnt == 4'h8) ? 1'b0 : ~tx_sh[6]; // see [RQ5]
                end
                default: begin
                    sda_low <= 1'b0; // see [RQ3] see [RQ19]
                end
            endcase
        end
    end

    // ================================================================
    // Line mode and completion pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_mode   <= 1'b0;
            read_done <= 1'b0;
        end else begin
            if (state == D_RXB && scl_rise && last_bit && is_mcode) hs_mode <= 1'b1; // see [RQ3]
            else if (bus_stop) hs_mode <= 1'b0; // see [RQ15]
            read_done <= (state == D_ACK_M) && scl_rise && !m_ack && !more; // see [RQ13]
        end
    end
endmodule
`default_nettype wire

// >>> hdl/hsdr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hsdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ================================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // Wrap at DEPTH so that depths other than powers of two work
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Handshake flags straight from the count
    assign in_ready  = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Pointer and count update
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= bump(wr_ptr);
            if (pop) rd_ptr <= bump(rd_ptr);
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    // Data write, no reset needed on storage
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule
`default_nettype wire

// >>> hdl/hsdr_master.sv
`timescale 1ns/1ps
`default_nettype none
module hsdr_master #(
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Bus side
    hsdr_if.mst       bus,
    // Command
    input  wire logic go,
    output logic      busy,
    input  wire logic sel,
    // Read bytes out
    output logic      rd_valid,
    input  wire logic rd_ready,
    output logic [7:0] rd_data,
    // Status
    output logic      done,
    output logic      nack_err
);
    // ================================================================
    // States
    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_BIT   = 4'h4,
        M_STOP  = 4'h8
    } hsdr_mstate_e;

    hsdr_mstate_e state;
    logic [1:0]   q;
    logic [7:0]   qcnt;
    logic [2:0]   byte_i;
    logic [3:0]   bit_i;
    logic [7:0]   tx_sh;
    logic [7:0]   rx_sh;
    logic         sda_s1;
    logic         sda_s2;
    logic         scl_r;
    logic         sda_low;

    // ================================================================
    // Decode
    wire reading  = (byte_i >= 3'h2);
    wire ack_slot = (bit_i == 4'h8);
    wire fifo_rdy;
    // Clock is held low before the ninth bit while the FIFO is full
    wire stall    = (state == M_BIT) && ack_slot && reading && (q == 2'h0) && !fifo_rdy;
    wire tick     = (qcnt == 8'(hsdr_pkg::QUARTER_CYC - 1)) && !stall;
    wire slot_end = tick && (q == 2'h3);
    wire push     = tick && (state == M_BIT) && ack_slot && reading && (q == 2'h0);
    wire m_drive  = reading ? ack_slot : !ack_slot;
    wire bit_val  = ack_slot ? (byte_i == 3'h4) : tx_sh[7]; // see [RQ9] see [RQ11] see [RQ13]
    wire scl_hi   = (q == 2'h1) || (q == 2'h2);

    // Wanted line levels per state and quarter
    wire want_scl = (state == M_IDLE) || (state == M_STOP ? q != 2'h0 : scl_hi);
    wire want_low = (state == M_START) ? q[1] :
                    (state == M_STOP)  ? !q[1] :
                    (state == M_BIT)   ? (m_drive && !bit_val) : 1'b0;

    assign bus.scl_o    = scl_r;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = sda_low;
    assign busy         = (state != M_IDLE);

    hsdr_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (rx_sh),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // ================================================================
    // SDA synchroniser and registered line drivers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_s1  <= 1'b1;
            sda_s2  <= 1'b1;
            scl_r   <= 1'b1;
            sda_low <= 1'b0;
        end else begin
            sda_s1  <= bus.sda;
            sda_s2  <= sda_s1;
            scl_r   <= want_scl;
            sda_low <= want_low;
        end
    end

    // Quarter timer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qcnt <= 8'h00;
            q    <= 2'h0;
        end else if (state == M_IDLE) begin
            qcnt <= 8'h00;
            q    <= 2'h0;
        end else if (tick) begin
            qcnt <= 8'h00;
            q    <= q + 2'h1;
        end else if (!stall) begin
            qcnt <= qcnt + 8'h01;
        end
    end

    // ================================================================
    // Sequencer: start, code, restart, address, three bytes, stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= M_IDLE;
            byte_i   <= 3'h0;
            bit_i    <= 4'h0;
            tx_sh    <= 8'h00;
            rx_sh    <= 8'h00;
            done     <= 1'b0;
            nack_err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (tick && q == 2'h1 && state == M_BIT && !ack_slot) rx_sh <= {rx_sh[6:0], sda_s2};
            unique case (state)
                M_IDLE: begin
                    if (go) begin
                        state    <= M_START;
                        byte_i   <= 3'h0;
                        nack_err <= 1'b0;
                    end
                end
                M_START: begin
                    if (slot_end) begin
                        state <= M_BIT;
                        bit_i <= 4'h0;
                        tx_sh <= (byte_i == 3'h0) ? hsdr_pkg::MCODE_BYTE
                                                  : hsdr_pkg::addr_byte(sel, 1'b1);
                    end
                end
                M_BIT: begin
                    if (tick && q == 2'h1 && ack_slot && byte_i == 3'h1 && sda_s2) begin
                        nack_err <= 1'b1;
                    end
                    if (slot_end && !ack_slot) begin
                        bit_i <= bit_i + 4'h1;
                        tx_sh <= {tx_sh[6:0], 1'b0};
                    end else if (slot_end) begin
                        bit_i  <= 4'h0;
                        byte_i <= byte_i + 3'h1;
                        if (byte_i == 3'h0) state <= M_START;
                        else if (byte_i == 3'h4 || nack_err) state <= M_STOP;
                    end
                end
                M_STOP: begin
                    if (slot_end) begin
                        state <= M_IDLE;
                        done  <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> pkg/hsdr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hsdr_if;
    // ================================================================
    // Drivers: SCL is push-pull from the master, SDA is open drain
    logic scl_o;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    // Resolved levels, SDA pulled up when nobody pulls low
    wire  scl;
    wire  sda;

    assign scl = scl_o;
    assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport mst (output scl_o, output m_sda_o, output m_sda_oe, input sda);
endinterface
`default_nettype wire

// >>> pkg/hsdr_pkg.sv
`default_nettype none
package hsdr_pkg;
    // ================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 160;
    // Master splits each SCL period into four quarters
    localparam int QUARTER_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    // ================================================================
    // Bus codes
    localparam logic [4:0] ADDR_PREFIX  = 5'h13;
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    localparam logic [7:0] MCODE_BYTE   = 8'h08;
    localparam int         BYTES_READ   = 3;

    // ================================================================
    // Returned control byte: source field
    localparam int         LOAD_LSB  = 4;
    localparam logic [1:0] LOAD_TEMP = 2'h0;
    localparam logic [1:0] LOAD_DAC  = 2'h1;

    // Address byte: prefix, select bit, fixed zero, direction
    function automatic logic [7:0] addr_byte(input logic sel, input logic rd);
        addr_byte = {ADDR_PREFIX, sel, 1'b0, rd};
    endfunction
endpackage
`default_nettype wire

// >>> test/hsdr_props.sv
`timescale 1ns/1ps
`default_nettype none
module hsdr_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link drivers and resolved lines
    input wire logic scl_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    // ================================================================
    // Frame tracking
    logic       scl_q, sda_q;
    logic [3:0] bitc;
    logic [2:0] nbyte;
    logic [7:0] shreg;
    wire        rise  = scl && !scl_q;
    wire        start = scl && scl_q && sda_q && !sda;
    wire        ninth = rise && bitc == 4'h8;

    // Counts restart at every start, so a repeated start reopens byte zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            bitc  <= 4'h0;
            nbyte <= 3'h0;
            shreg <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                bitc  <= 4'h0;
                nbyte <= 3'h0;
            end else if (ninth) begin
                bitc  <= 4'h0;
                nbyte <= nbyte + 3'h1;
            end else if (rise) begin
                bitc  <= bitc + 4'h1;
                shreg <= {shreg[6:0], sda};
            end
        end
    end

    // ================================================================
    // Properties
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_scl_high_len: assert property ($rose(scl_o) |=> scl_o [*7])
        else $error("SCL high phase too short");
    a_scl_low_len: assert property ($fell(scl_o) |=> !scl_o [*3])
        else $error("SCL low phase too short");
    a_mst_hold_high: assert property ($rose(scl_o) |=> $stable(m_sda_oe) [*3])
        else $error("master SDA moved while SCL high");
    a_dev_chg_low: assert property ($changed(d_sda_oe)
        |-> !scl && !$past(scl) && !$past(scl, 2))
        else $error("device SDA moved too close to SCL high");
    a_start_by_mst: assert property (start |-> m_sda_oe)
        else $error("start not made by master");
    a_mcode_nack: assert property (ninth && nbyte == 3'h0
        && shreg[7:3] == hsdr_pkg::MCODE_PREFIX |-> !d_sda_oe)
        else $error("master code acknowledged");
    a_addr_refuse: assert property (ninth && nbyte == 3'h0
        && (shreg[7:3] != hsdr_pkg::ADDR_PREFIX || shreg[1] || !shreg[0]) |-> !d_sda_oe)
        else $error("foreign address acknowledged");
    a_ack_held: assert property (rise && d_sda_oe |-> d_sda_oe [*8])
        else $error("device low not held through SCL high");
    a_rel_after_nack: assert property (ninth && nbyte == 3'h3 && sda |=> !d_sda_oe [*8])
        else $error("device drives after final not-acknowledge");
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ================================================================
    // Stimulus and observation
    logic        clk, resetn, go, sel, rd_ready, src_temp, pin, ack, hs_hit;
    logic [15:0] dac_w, tmp_w;
    logic [7:0]  ctrl, rd_data;
    logic        busy, rd_valid, done, nack_err, hs_mode, hs_b, read_done;
    int          rd_cnt, err_total, n_compared, cyc;

    hsdr_if b1();
    hsdr_if b2();

    // Design pair on the first link
    hsdr_master #(.DEPTH(4)) u_hsdr_master (
        .clk(clk), .resetn(resetn), .bus(b1), .go(go), .busy(busy), .sel(sel),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .done(done), .nack_err(nack_err));
    hsdr_device u_hsdr_device (
        .clk(clk), .resetn(resetn), .bus(b1), .dac_word(dac_w), .temp_word(tmp_w),
        .src_temp(src_temp), .ctrl_in(ctrl), .address_select_pin(pin),
        .hs_mode(hs_mode), .read_done(read_done));
    // Second device, bit-banged to break the sequence on purpose
    hsdr_device u_hsdr_device_b (
        .clk(clk), .resetn(resetn), .bus(b2), .dac_word(dac_w), .temp_word(tmp_w),
        .src_temp(src_temp), .ctrl_in(ctrl), .address_select_pin(pin),
        .hs_mode(hs_b), .read_done());
    hsdr_props u_hsdr_props (
        .clk(clk), .resetn(resetn), .scl_o(b1.scl_o), .m_sda_oe(b1.m_sda_oe),
        .d_sda_oe(b1.d_sda_oe), .scl(b1.scl), .sda(b1.sda));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Sticky flags and hang guard, sampled away from the launching edge
    always @(negedge clk) begin
        if (hs_mode === 1'h1) hs_hit = 1'h1;
        if (read_done === 1'h1) rd_cnt++;
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end

    // ================================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [7:0] cexp(input logic t);
        cexp = {ctrl[7:6], t ? hsdr_pkg::LOAD_TEMP : hsdr_pkg::LOAD_DAC, ctrl[3:0]};
    endfunction

    task automatic start_rd(input logic s, input logic t);
        @(posedge clk);
        go       <= 1'h1;
        sel      <= s;
        src_temp <= t;
        @(posedge clk);
        go <= 1'h0;
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 2000 && done !== 1'h1; k++) @(negedge clk);
        check({15'h0, k < 2000}, 16'h1);
    endtask

    // Take one byte; rd_ready is held a single cycle so one word leaves
    task automatic pop(input logic [7:0] exp);
        int k;
        @(negedge clk);
        for (k = 0; k < 4000 && rd_valid !== 1'h1; k++) @(negedge clk);
        check({8'h00, rd_data}, {8'h00, exp});
        @(posedge clk);
        rd_ready <= 1'h1;
        @(posedge clk);
        rd_ready <= 1'h0;
    endtask

    task automatic rd_full(input logic t);
        logic [15:0] w;
        int          n;
        w      = t ? tmp_w : dac_w;
        n      = rd_cnt;
        hs_hit = 1'h0;
        start_rd(pin, t);
        wait_done();
        check({15'h0, nack_err}, 16'h0);
        check({15'h0, hs_hit}, 16'h1);
        check(16'(rd_cnt - n), 16'h1);
        pop(w[15:8]);
        pop(w[7:0]);
        pop(cexp(t));
        check({15'h0, hs_mode}, 16'h0);
    endtask

    // One quarter of an SCL period on the second link
    task automatic bb_q(input logic c, input logic d);
        @(posedge clk);
        b2.scl_o    <= c;
        b2.m_sda_oe <= ~d;
        repeat (hsdr_pkg::QUARTER_CYC - 1) @(posedge clk);
    endtask

    // SDA is set in the first low quarter and kept through the high half
    task automatic bb_bit(input logic b, output logic s);
        bb_q(1'h0, b);
        bb_q(1'h1, b);
        @(negedge clk);
        s = b2.sda;
        bb_q(1'h1, b);
        bb_q(1'h0, b);
    endtask

    task automatic bb_byte(input logic [7:0] v, output logic a);
        for (int i = 7; i >= 0; i--) bb_bit(v[i], a);
        bb_bit(1'h1, a);
    endtask

    task automatic bb_start();
        bb_q(1'h0, 1'h1);
        bb_q(1'h1, 1'h1);
        bb_q(1'h1, 1'h0);
        bb_q(1'h0, 1'h0);
    endtask

    // ================================================================
    // Sequence
    initial begin
        resetn = 1'h0;
        go = 1'h0;
        sel = 1'h0;
        rd_ready = 1'h0;
        src_temp = 1'h0;
        pin = 1'h1;
        dac_w = 16'ha5c3;
        tmp_w = 16'h3c96;
        ctrl = 8'hff;
        b2.scl_o = 1'h1;
        b2.m_sda_o = 1'h0;
        b2.m_sda_oe = 1'h0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        rd_cnt = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        @(negedge clk);
        check({14'h0, busy, b1.d_sda_oe}, 16'h0);
        // Both sources; flag bits are overwritten either way
        rd_full(1'h0);
        @(posedge clk);
        ctrl <= 8'h3a;
        rd_full(1'h1);
        // Select bit not matching the pin: refused, nothing read
        start_rd(1'h0, 1'h0);
        wait_done();
        check({15'h0, nack_err}, 16'h1);
        check({15'h0, rd_valid}, 16'h0);
        // Reset in mid-read, with the pin moved meanwhile
        start_rd(1'h1, 1'h0);
        repeat (300) @(posedge clk);
        resetn <= 1'h0;
        pin    <= 1'h0;
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        @(negedge clk);
        check({13'h0, busy, hs_mode, b1.scl}, 16'h1);
        // Six bytes into four words: the second read stalls with SCL low
        start_rd(1'h0, 1'h0);
        wait_done();
        start_rd(1'h0, 1'h0);
        repeat (1500) @(posedge clk);
        @(negedge clk);
        check({14'h0, busy, b1.scl}, 16'h2);
        for (int j = 0; j < 2; j++) begin
            pop(dac_w[15:8]);
            pop(dac_w[7:0]);
            pop(cexp(1'h0));
        end
        wait_done();
        // Code, broadcast read and foreign select on the second link
        bb_start();
        bb_byte(hsdr_pkg::MCODE_BYTE, ack);
        check({15'h0, ack}, 16'h1);
        check({15'h0, hs_b}, 16'h1);
        bb_start();
        bb_byte(8'h91, ack);
        check({15'h0, ack}, 16'h1);
        bb_start();
        bb_byte(8'h9d, ack);
        check({15'h0, ack}, 16'h1);
        bb_q(1'h0, 1'h0);
        bb_q(1'h1, 1'h0);
        bb_q(1'h1, 1'h1);
        repeat (8) @(posedge clk);
        check({15'h0, hs_b}, 16'h0);
        results();
    end
endmodule
`default_nettype wire
